/* File: core/ftsc_pkg.sv */
package ftsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BOUND1   = 8'hA6;
  localparam logic [7:0] IDX_BOUND2   = 8'hA9;
  localparam logic [7:0] IDX_SEG1     = 8'hAA;
  localparam logic [7:0] IDX_SEG2     = 8'hAB;
  localparam logic [7:0] IDX_SEG3     = 8'hAE;
  localparam logic [7:0] IDX_CTRL     = 8'hAF;
  localparam logic [7:0] IDX_EXPECT   = 8'hA3;
  localparam logic [7:0] IDX_STATUS   = 8'hA7;
  localparam int         ADR_LSB      = 2;
  // Reset values
  localparam logic [7:0] BOUND1_RST   = 8'h3C;
  localparam logic [7:0] BOUND2_RST   = 8'h1E;
  localparam logic [7:0] SEG1_RST     = 8'hFF;
  localparam logic [7:0] SEG2_RST     = 8'hD9;
  localparam logic [7:0] SEG3_RST     = 8'h80;
  localparam logic [7:0] CTRL_RST     = 8'h1D;
  localparam logic [7:0] EXPECT_RST   = 8'h80;
  // Control register fields
  localparam int         CTRL_SRC_DIG = 7;
  localparam int         CTRL_FREQ    = 6;
  localparam int         CTRL_FORCE   = 5;
  localparam int         CTRL_INTERP  = 4;
  localparam int         CTRL_JHIGH   = 3;
  localparam int         CTRL_JLOW    = 2;
  localparam int         CTRL_SRC_HI  = 1;
  localparam int         CTRL_SRC_LO  = 0;
  // Channel modes
  localparam logic [1:0] MODE_SPEED   = 2'b00;
  localparam logic [1:0] MODE_DUTY    = 2'b01;
  // Full-speed encodings per mode
  localparam logic [7:0] FULL_DUTY    = 8'hFF;
  localparam logic [7:0] FULL_SPEED   = 8'h00;
  // Timing
  localparam int         CLK_HZ       = 100000000;
  localparam int         PWM_STEPS    = 256;
  localparam int         PWM_FAST_HZ10 = 235000;
  localparam int         PWM_SLOW_HZ10 = 2200;
  localparam int         PRE_FAST     = (CLK_HZ / PWM_STEPS * 10) / PWM_FAST_HZ10;
  localparam int         PRE_SLOW     = (CLK_HZ / PWM_STEPS * 10) / PWM_SLOW_HZ10;
  localparam int         STEP_TIME_US = 1000;
  localparam int         STEP_CYCLES_DEF = STEP_TIME_US * (CLK_HZ / 1000000);
  localparam int         TEMP_SOURCES = 8;
  typedef enum logic [1:0] {FTSC_SEG1, FTSC_SEG2, FTSC_SEG3} ftsc_seg_t;
endpackage : ftsc_pkg

/* File: core/ftsc_top.sv */
// Summary of operation
// RQ1 - Second boundary picks segment two or three
// RQ2 - Boundaries compare as signed two's complement
// RQ3 - Mode 00: segment bytes mean relative speed
// RQ4 - Software writes zero for full speed
// RQ5 - Mode 01: segment bytes are duty directly
// RQ6 - Three-bit code selects temperature source
// RQ7 - Frequency bit picks 23.5 kHz or 220 Hz
// RQ8 - Force bit gives full speed over limits
// RQ9 - Interpolation bit smooths between segments
// RQ10 - Above top boundary: ramp or jump up
// RQ11 - Below top boundary minus hysteresis: ramp or jump
// RQ12 - Jump bits only count in duty mode
// RQ13 - First boundary picks segment one or two
// RQ14 - Inside hysteresis band keep previous segment
`timescale 1ns/1ps
module ftsc_top
  import ftsc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic [63:0] temp_sources_i,
  input  wire logic        over_limit_i,
  input  wire logic [1:0]  channel_mode_field_i,
  input  wire logic [7:0]  hysteresis_i,
  input  wire logic [1:0]  duty_slope_select_i,
  input  wire logic [7:0]  speed_loop_duty_i,
  output logic      [7:0]  expected_value_o,
  output logic             full_speed_o,
  output logic             pwm_o
);

  logic [7:0]  bound1, bound2, seg1_val, seg2_val, seg3_val, ctrl;
  logic [7:0]  next_bound1, next_bound2, next_seg1, next_seg2, next_seg3, next_ctrl;
  logic        next_ack;
  logic [31:0] next_rdata;
  ftsc_seg_t   seg, next_seg;
  logic        came_down, next_came_down;
  logic [7:0]  expect_q, next_expect;
  logic        forced, next_forced;
  logic [23:0] tick_cnt, next_tick_cnt;
  logic [11:0] pre_cnt, next_pre_cnt;
  logic [7:0]  pwm_cnt, next_pwm_cnt;
  logic        next_pwm;

  logic [7:0]  idx;
  logic        wr_en;
  logic [2:0]  src_code;
  logic [7:0]  temp_sel;
  logic [7:0]  src_temp [TEMP_SOURCES];
  logic [9:0]  t_ext, b1_ext, b2_ext, b1_low, b2_low;
  logic        duty_mode;
  logic [7:0]  target;
  logic        immediate;
  logic        tick;
  logic [23:0] tick_max;
  logic [11:0] pre_max;
  logic [7:0]  pwm_duty;

  // Bus decode; a write lands on the edge that sees ack high
  assign idx   = wb_adr_i[9:ADR_LSB];
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;

  // Register file next values
  always_comb begin
    next_bound1 = bound1;
    next_bound2 = bound2;
    next_seg1   = seg1_val;
    next_seg2   = seg2_val;
    next_seg3   = seg3_val;
    next_ctrl   = ctrl;
    if (wr_en) begin
      case (idx)
        IDX_BOUND1: next_bound1 = wb_dat_i[7:0];
        IDX_BOUND2: next_bound2 = wb_dat_i[7:0];
        IDX_SEG1:   next_seg1   = wb_dat_i[7:0];
        IDX_SEG2:   next_seg2   = wb_dat_i[7:0];
        IDX_SEG3:   next_seg3   = wb_dat_i[7:0];
        IDX_CTRL:   next_ctrl   = wb_dat_i[7:0];
        default:    ;
      endcase
    end
  end

  // Bus answer: one-cycle ack, byte-wide read data
  // Upper data bits stay zero so wide reads never see stale bits
  always_comb begin
    next_ack   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_rdata = 32'h0000_0000;
    case (idx)
      IDX_BOUND1: next_rdata[7:0] = bound1;
      IDX_BOUND2: next_rdata[7:0] = bound2;
      IDX_SEG1:   next_rdata[7:0] = seg1_val;
      IDX_SEG2:   next_rdata[7:0] = seg2_val;
      IDX_SEG3:   next_rdata[7:0] = seg3_val;
      IDX_CTRL:   next_rdata[7:0] = ctrl;
      IDX_EXPECT: next_rdata[7:0] = expect_q;
      IDX_STATUS: next_rdata[7:0] = {5'b00000, forced, seg};
      default:    next_rdata      = 32'h0000_0000;
    endcase
  end

  // Register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bound1   <= BOUND1_RST;
      bound2   <= BOUND2_RST;
      seg1_val <= SEG1_RST;
      seg2_val <= SEG2_RST;
      seg3_val <= SEG3_RST;
      ctrl     <= CTRL_RST;
    end else begin
      bound1   <= next_bound1;
      bound2   <= next_bound2;
      seg1_val <= next_seg1;
      seg2_val <= next_seg2;
      seg3_val <= next_seg3;
      ctrl     <= next_ctrl;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // Unpack the eight signed source bytes, one per source code
  for (genvar g = 0; g < TEMP_SOURCES; g++) begin : g_src
    assign src_temp[g] = temp_sources_i[g*8 +: 8];
  end

  // Temperature source select
  // The digital-select bit forms the top bit of the code
  assign src_code = {ctrl[CTRL_SRC_DIG], ctrl[CTRL_SRC_HI:CTRL_SRC_LO]}; // RQ6
  assign temp_sel = src_temp[src_code]; // RQ6

  // Signed compares against boundaries and their hysteresis floors
  assign t_ext  = {{2{temp_sel[7]}}, temp_sel}; // RQ2
  assign b1_ext = {{2{bound1[7]}}, bound1}; // RQ2
  assign b2_ext = {{2{bound2[7]}}, bound2}; // RQ2
  assign b1_low = b1_ext - {2'b00, hysteresis_i};
  assign b2_low = b2_ext - {2'b00, hysteresis_i};
  assign duty_mode = (channel_mode_field_i == MODE_DUTY);

  // Segment tracking with hysteresis
  always_comb begin
    next_seg       = seg;
    next_came_down = came_down;
    case (seg)
      FTSC_SEG1: begin
        if ($signed(t_ext) < $signed(b1_low)) begin // RQ13
          next_seg       = FTSC_SEG2;
          next_came_down = 1'b1;
        end
      end
      FTSC_SEG2: begin
        if ($signed(t_ext) > $signed(b1_ext)) begin // RQ13
          next_seg       = FTSC_SEG1;
          next_came_down = 1'b0;
        end else if ($signed(t_ext) < $signed(b2_low)) begin // RQ1
          next_seg       = FTSC_SEG3;
          next_came_down = 1'b0;
        end
      end
      FTSC_SEG3: begin
        if ($signed(t_ext) > $signed(b2_ext)) begin // RQ1
          next_seg       = FTSC_SEG2;
        end
      end
      default: next_seg = FTSC_SEG3;
    endcase
    // Otherwise the band holds the earlier choice
    if (next_seg == seg && seg != FTSC_SEG2) begin // RQ14
      next_came_down = 1'b0;
    end
  end

  // Segment value and movement policy
  always_comb begin
    next_forced = ctrl[CTRL_FORCE] & over_limit_i; // RQ8
    case (seg)
      FTSC_SEG1: target = seg1_val; // RQ3 RQ5
      FTSC_SEG2: target = seg2_val; // RQ3 RQ5
      default:   target = seg3_val; // RQ3 RQ5
    endcase
    // Full speed is FFh duty or a zero relative byte
    if (next_forced) begin
      target = duty_mode ? FULL_DUTY : FULL_SPEED; // RQ4 RQ8
    end
    if (next_forced) begin
      immediate = 1'b1;
    end else if (duty_mode && seg == FTSC_SEG1) begin // RQ12
      immediate = ctrl[CTRL_JHIGH]; // RQ10
    end else if (duty_mode && seg == FTSC_SEG2 && came_down) begin // RQ12
      immediate = ctrl[CTRL_JLOW]; // RQ11
    end else begin
      immediate = ~ctrl[CTRL_INTERP]; // RQ9
    end
  end

  // Slope tick divider
  // Higher slope selects stretch the step period by powers of two
  assign tick_max = 24'(STEP_CYCLES - 1) << duty_slope_select_i;
  assign tick     = (tick_cnt >= tick_max);
  always_comb begin
    next_tick_cnt = tick ? 24'h00_0000 : tick_cnt + 24'h00_0001;
  end

  // Expected value, jumping or stepping toward the target
  always_comb begin
    next_expect = expect_q;
    if (immediate) begin
      next_expect = target; // RQ10 RQ11
    end else if (tick && expect_q < target) begin
      next_expect = expect_q + 8'h01; // RQ10 RQ9
    end else if (tick && expect_q > target) begin
      next_expect = expect_q - 8'h01; // RQ11 RQ9
    end
  end

  // PWM prescale and counter
  assign pre_max  = next_ctrl[CTRL_FREQ] ? 12'(PRE_SLOW - 1) : 12'(PRE_FAST - 1); // RQ7
  assign pwm_duty = duty_mode ? expect_q : speed_loop_duty_i; // RQ5
  always_comb begin
    next_pre_cnt = pre_cnt + 12'h001;
    next_pwm_cnt = pwm_cnt;
    if (pre_cnt >= pre_max) begin // RQ7
      next_pre_cnt = 12'h000;
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
    next_pwm = (pwm_duty == FULL_DUTY) | (pwm_cnt < pwm_duty);
  end

  // Segment state
  // Reset starts in the coolest segment, matching the reset expected value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg       <= FTSC_SEG3;
      came_down <= 1'b0;
    end else begin
      seg       <= next_seg;
      came_down <= next_came_down;
    end
  end

  // Force flag and its output copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      forced       <= 1'b0;
      full_speed_o <= 1'b0;
    end else begin
      forced       <= next_forced; // RQ8
      full_speed_o <= next_forced; // RQ8
    end
  end

  // Expected value, its output copy and the slope divider
  // The output copy keeps the port straight from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expect_q         <= EXPECT_RST;
      expected_value_o <= EXPECT_RST;
      tick_cnt         <= 24'h00_0000;
    end else begin
      expect_q         <= next_expect;
      expected_value_o <= next_expect;
      tick_cnt         <= next_tick_cnt;
    end
  end

  // PWM counters and output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 12'h000;
      pwm_cnt <= 8'h00;
      pwm_o   <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      pwm_cnt <= next_pwm_cnt;
      pwm_o   <= next_pwm;
    end
  end

endmodule : ftsc_top

/* File: dv/ftsc_checker.sv */
`timescale 1ns/1ps
module ftsc_checker
  import ftsc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        over_limit_i,
  input wire logic [1:0]  channel_mode_field_i,
  input wire logic [7:0]  speed_loop_duty_i,
  input wire logic [7:0]  expected_value_o,
  input wire logic        full_speed_o,
  input wire logic        pwm_o
);
  logic dm;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Duty mode flag
  assign dm = channel_mode_field_i == MODE_DUTY;
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits set");
  force_cause_a: assert property ($rose(full_speed_o) |-> $past(over_limit_i))
    else $error("force without over limit");
  force_duty_a: assert property (full_speed_o && dm && $stable(dm) |->
    expected_value_o == FULL_DUTY) else $error("forced duty wrong");
  pwm_full_a: assert property ((dm && expected_value_o == FULL_DUTY) [*3] |=> pwm_o)
    else $error("pwm low at full duty");
  pwm_zero_a: assert property ((dm && expected_value_o == 8'h00) [*3] |=> !pwm_o)
    else $error("pwm high at zero duty");
  speed_pwm_a: assert property ((!dm && speed_loop_duty_i == 8'hFF) [*3] |=> pwm_o)
    else $error("speed mode pwm low");
  // Main scenarios
  cover property (full_speed_o && dm);
  cover property (wb_ack_o && wb_dat_o != 32'h0);
  cover property ($rose(pwm_o));
endmodule : ftsc_checker
bind ftsc_top ftsc_checker i_ftsc_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .over_limit_i, .channel_mode_field_i, .speed_loop_duty_i,
  .expected_value_o, .full_speed_o, .pwm_o);

/* File: dv/tb_fan1_temp_segment_control.sv */
`timescale 1ns/1ps
module tb_fan1_temp_segment_control
  import ftsc_pkg::*;
  ;
  `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, over_limit_i;
  logic        full_speed_o, pwm_o;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [63:0] temp_sources_i;
  logic [1:0]  channel_mode_field_i, duty_slope_select_i;
  logic [7:0]  hysteresis_i, speed_loop_duty_i, expected_value_o, rv;
  int          miscompares, samples_checked, cycles;
  time         t0;
  logic [7:0]  idx_t [6] = '{IDX_BOUND1, IDX_BOUND2, IDX_SEG1, IDX_SEG2, IDX_SEG3, IDX_CTRL};
  logic [7:0]  rst_t [6] = '{BOUND1_RST, BOUND2_RST, SEG1_RST, SEG2_RST, SEG3_RST, CTRL_RST};
  logic [7:0]  cfg_t [6] = '{8'h3C, 8'h1E, 8'h40, 8'h30, 8'h00, 8'h0D};
  logic [7:0]  st_t [7] = '{8'h14, 8'h28, 8'h1C, 8'h18, 8'h46, 8'h39, 8'h32};
  logic [7:0]  st_e [7] = '{8'h00, 8'h30, 8'h30, 8'h00, 8'h40, 8'h40, 8'h30};
  logic [7:0]  ct_t [3] = '{8'h1D, 8'h15, 8'h1D};

  ftsc_top #(.STEP_CYCLES(4)) i_ftsc_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .temp_sources_i, .over_limit_i,
    .channel_mode_field_i, .hysteresis_i, .duty_slope_select_i, .speed_loop_duty_i,
    .expected_value_o, .full_speed_o, .pwm_o);

  // Clock and hang guard
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_i);
      cycles++;
      if (cycles > 10000) begin
        miscompares++;
        stop_test();
      end
    end
  end

  // One classic bus cycle, read byte lands in rv
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rv = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  // Temperature on source one, then settle
  task automatic step(input logic [7:0] t, input logic [7:0] e);
    temp_sources_i[15:8] <= t;
    repeat (4) @(posedge clk_i);
    `CHK("expected", e, expected_value_o)
  endtask : step

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // Test sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, over_limit_i} = 4'h0;
    wb_adr_i = 10'h000;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    temp_sources_i = 64'h0;
    channel_mode_field_i = MODE_DUTY;
    duty_slope_select_i = 2'h0;
    hysteresis_i = 8'h05;
    speed_loop_duty_i = 8'hFF;
    miscompares = 0;
    samples_checked = 0;
    rst_i = 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      wb(1'h0, idx_t[i], 8'h00, 4'hF);
      `CHK("reset value", rst_t[i], rv)
      wb(1'h1, idx_t[i], 8'h5A, 4'hF);
      wb(1'h0, idx_t[i], 8'h00, 4'hF);
      `CHK("readback", 8'h5A, rv)
    end
    wb(1'h1, IDX_SEG1, 8'h40, 4'hE);
    wb(1'h0, IDX_SEG1, 8'h00, 4'hF);
    `CHK("masked write", 8'h5A, rv)
    wb(1'h1, 8'hB0, 8'h77, 4'hF);
    wb(1'h0, 8'hB0, 8'h00, 4'hF);
    `CHK("unmapped", 8'h00, rv)
    $display("test registers done");
    for (int i = 0; i < 6; i++) wb(1'h1, idx_t[i], cfg_t[i], 4'hF);
    for (int i = 0; i < 7; i++) step(st_t[i], st_e[i]);
    wb(1'h1, IDX_BOUND2, 8'hF6, 4'hF);
    step(8'hF0, 8'h00);
    step(8'h05, 8'h30);
    wb(1'h0, IDX_STATUS, 8'h00, 4'hF);
    `CHK("status", 8'h01, rv)
    wb(1'h1, IDX_EXPECT, 8'h77, 4'hF);
    wb(1'h0, IDX_EXPECT, 8'h00, 4'hF);
    `CHK("expect read", 8'h30, rv)
    $display("test segments done");
    for (int n = 0; n < TEMP_SOURCES; n++) begin
      temp_sources_i <= {8{8'h80}};
      wb(1'h1, IDX_CTRL, {n[2], 5'h03, n[1:0]}, 4'hF);
      repeat (4) @(posedge clk_i);
      `CHK("cold source", 8'h00, expected_value_o)
      temp_sources_i[8*n +: 8] <= 8'h46;
      repeat (4) @(posedge clk_i);
      `CHK("hot source", 8'h40, expected_value_o)
    end
    $display("test sources done");
    temp_sources_i <= {8{8'h80}};
    over_limit_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    `CHK("no force", 1'h0, full_speed_o)
    wb(1'h1, IDX_CTRL, 8'h2D, 4'hF);
    repeat (8) @(posedge clk_i);
    `CHK("forced", 1'h1, full_speed_o)
    `CHK("forced duty", FULL_DUTY, expected_value_o)
    wb(1'h0, IDX_STATUS, 8'h00, 4'hF);
    `CHK("forced status", 8'h06, rv)
    channel_mode_field_i <= MODE_SPEED;
    repeat (4) @(posedge clk_i);
    `CHK("forced speed", FULL_SPEED, expected_value_o)
    over_limit_i <= 1'h0;
    channel_mode_field_i <= MODE_DUTY;
    repeat (4) @(posedge clk_i);
    `CHK("released", 1'h0, full_speed_o)
    $display("test force done");
    for (int k = 0; k < 3; k++) begin
      channel_mode_field_i <= (k == 2) ? MODE_SPEED : MODE_DUTY;
      temp_sources_i <= {8{8'h80}};
      wb(1'h1, IDX_CTRL, ct_t[k], 4'hF);
      repeat (400) @(posedge clk_i);
      temp_sources_i <= {8{8'h46}};
      repeat (6) @(posedge clk_i);
      `CHK("jump", k == 0, expected_value_o == 8'h40)
      repeat (400) @(posedge clk_i);
      `CHK("ramp end", 8'h40, expected_value_o)
    end
    $display("test ramp done");
    // Mid-run reset, then time the first PWM step at each frequency
    for (int f = 0; f < 2; f++) begin
      temp_sources_i <= {8{8'h80}};
      channel_mode_field_i <= MODE_DUTY;
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      t0 = $time;
      wb(1'h1, IDX_SEG3, 8'h01, 4'hF);
      wb(1'h1, IDX_CTRL, {1'h0, f[0], 6'h0D}, 4'hF);
      @(negedge pwm_o);
      `CHK("pwm step", (f == 0) ? PRE_FAST + 1 : PRE_SLOW + 1, ($time - t0) / 10)
    end
    $display("test frequency done");
    stop_test();
  end
endmodule : tb_fan1_temp_segment_control
